/* logic/mdbp_master.sv */
// module end: dma bus master running shared memory cycles
`timescale 1ns/1ns
`default_nettype none
module mdbp_master #(
  parameter int BURST_MAX = mdbp_pkg::MDBP_BURST_MAX
) (
  input wire logic mclk,
  input wire logic resetn,
  mdbp_if.master bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire mdbp_pkg::mdbp_addr_t cmd_addr,
  input wire mdbp_pkg::mdbp_be_t cmd_be,
  input wire mdbp_pkg::mdbp_len_t cmd_len,
  input wire logic cmd_extend,
  input wire logic cmd_lock,
  input wire logic [BURST_MAX*mdbp_pkg::MDBP_DATA_W-1:0] cmd_wdata,
  input wire logic hold_read,
  output logic rd_valid,
  output mdbp_pkg::mdbp_data_t rd_data,
  output logic xfer_done,
  output logic bus_owned
);
  import mdbp_pkg::*;

  mdbp_mstate_t state_reg, state_next;
  logic req_n_reg, req_n_next;
  logic ads_n_reg, ads_n_next;
  logic last_transfer_n_n_reg, last_transfer_n_n_next;
  logic ext_n_reg, ext_n_next;
  logic lock_n_reg, lock_n_next;
  logic ctrl_oe_reg, ctrl_oe_next;
  logic data_oe_reg, data_oe_next;
  logic wr_reg, wr_next;
  logic ext_ok_reg, ext_ok_next;
  logic rd_valid_reg, rd_valid_next;
  logic done_reg, done_next;
  mdbp_addr_t addr_reg, addr_next;
  mdbp_be_t be_reg, be_next;
  mdbp_len_t len_reg, len_next;
  mdbp_len_t cnt_reg, cnt_next;
  mdbp_data_t wdata_reg, wdata_next;
  mdbp_data_t rd_reg, rd_next;
  logic [BURST_MAX*MDBP_DATA_W-1:0] wbuf_reg, wbuf_next;
  mdbp_len_t len_eff;

  // bus outputs straight from registers
  assign bus.m_req_n = req_n_reg;
  assign bus.m_ads_n = ads_n_reg;
  assign bus.m_last_transfer_n_n = last_transfer_n_n_reg;
  assign bus.m_extend_n = ext_n_reg;
  assign bus.m_lock_n = lock_n_reg;
  assign bus.m_ctrl_oe = ctrl_oe_reg;
  assign bus.m_wr = wr_reg;
  assign bus.m_addr = addr_reg;
  assign bus.m_be = be_reg;
  assign bus.m_data = wdata_reg;
  assign bus.m_data_oe = data_oe_reg;

  // user side status
  assign cmd_ready = (state_reg == MDBP_M_OWN) && !bus.d_grant_n;
  assign rd_valid = rd_valid_reg;
  assign rd_data = rd_reg;
  assign xfer_done = done_reg;
  assign bus_owned = ctrl_oe_reg;

  // zero length means one transfer, clip to the burst limit
  always_comb begin
    if (cmd_len == '0) begin
      len_eff = MDBP_LEN_W'(1);
    end else if (cmd_len > MDBP_LEN_W'(BURST_MAX)) begin
      len_eff = MDBP_LEN_W'(BURST_MAX);
    end else begin
      len_eff = cmd_len;
    end
  end

  // ownership and cycle sequencing
  always_comb begin
    state_next = state_reg;
    req_n_next = req_n_reg;
    ads_n_next = ads_n_reg;
    last_transfer_n_n_next = last_transfer_n_n_reg;
    ext_n_next = ext_n_reg;
    lock_n_next = lock_n_reg;
    ctrl_oe_next = ctrl_oe_reg;
    data_oe_next = data_oe_reg;
    wr_next = wr_reg;
    ext_ok_next = ext_ok_reg;
    rd_valid_next = 1'b0;
    done_next = 1'b0;
    addr_next = addr_reg;
    be_next = be_reg;
    len_next = len_reg;
    cnt_next = cnt_reg;
    wdata_next = wdata_reg;
    rd_next = rd_reg;
    wbuf_next = wbuf_reg;
    case (state_reg)
      MDBP_M_IDLE: begin
        ctrl_oe_next = 1'b0;
        data_oe_next = 1'b0;
        if (cmd_valid) begin
          req_n_next = 1'b0;
          state_next = MDBP_M_REQ;
        end
      end
      MDBP_M_REQ: begin
        if (!bus.d_grant_n) begin
          ctrl_oe_next = 1'b1;
          state_next = MDBP_M_OWN;
        end
      end
      MDBP_M_OWN: begin
        if (bus.d_grant_n || !cmd_valid) begin
          // park: strobes high while still driven
          ads_n_next = 1'b1;
          last_transfer_n_n_next = 1'b1;
          ext_n_next = 1'b1;
          lock_n_next = 1'b1;
          data_oe_next = 1'b0;
          req_n_next = 1'b1;
          state_next = MDBP_M_PARK;
        end else begin
          // write data goes out with the strobe
          wr_next = cmd_write;
          addr_next = cmd_addr;
          be_next = cmd_be;
          len_next = len_eff;
          cnt_next = '0;
          wbuf_next = cmd_wdata;
          wdata_next = cmd_wdata[MDBP_DATA_W-1:0];
          data_oe_next = cmd_write;
          lock_n_next = ~cmd_lock;
          last_transfer_n_n_next = (len_eff != MDBP_LEN_W'(1));
          ext_ok_next = cmd_extend && !cmd_write && (len_eff == MDBP_LEN_W'(1));
          ads_n_next = 1'b0;
          state_next = MDBP_M_ADDR;
        end
      end
      MDBP_M_ADDR: begin
        ads_n_next = 1'b1;
        ext_n_next = ~(ext_ok_reg && hold_read);
        state_next = MDBP_M_DATA;
      end
      MDBP_M_DATA: begin
        if (!bus.d_ready_n && ext_n_reg) begin
          // transfer taken on ready with extend high, any wait count
          if (!wr_reg) begin
            rd_next = bus.data;
            rd_valid_next = 1'b1;
          end
          if (cnt_reg == len_reg - 1'b1) begin
            last_transfer_n_n_next = 1'b1;
            ext_n_next = 1'b1;
            data_oe_next = 1'b0;
            done_next = 1'b1;
            state_next = MDBP_M_OWN;
          end else begin
            cnt_next = cnt_reg + 1'b1;
            addr_next = addr_reg + 1'b1;
            wbuf_next = wbuf_reg >> MDBP_DATA_W;
            wdata_next = wbuf_reg[2*MDBP_DATA_W-1:MDBP_DATA_W];
            last_transfer_n_n_next = (cnt_reg + MDBP_LEN_W'(2) != len_reg);
          end
        end else begin
          // extend tracks the user hold, last-transfer keeps its value
          ext_n_next = ~(ext_ok_reg && hold_read);
        end
      end
      MDBP_M_PARK: begin
        ctrl_oe_next = 1'b0;
        state_next = MDBP_M_IDLE;
      end
      default: begin
        state_next = MDBP_M_IDLE;
        req_n_next = 1'b1;
        ctrl_oe_next = 1'b0;
        data_oe_next = 1'b0;
      end
    endcase
  end

  // state registers, synchronous reset to a released idle bus
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= MDBP_M_IDLE;
      req_n_reg <= 1'b1;
      ads_n_reg <= 1'b1;
      last_transfer_n_n_reg <= 1'b1;
      ext_n_reg <= 1'b1;
      lock_n_reg <= 1'b1;
      ctrl_oe_reg <= 1'b0;
      data_oe_reg <= 1'b0;
      wr_reg <= 1'b0;
      ext_ok_reg <= 1'b0;
      rd_valid_reg <= 1'b0;
      done_reg <= 1'b0;
      addr_reg <= '0;
      be_reg <= '1;
      len_reg <= MDBP_LEN_W'(1);
      cnt_reg <= '0;
      wdata_reg <= '0;
      rd_reg <= '0;
      wbuf_reg <= '0;
    end else begin
      state_reg <= state_next;
      req_n_reg <= req_n_next;
      ads_n_reg <= ads_n_next;
      last_transfer_n_n_reg <= last_transfer_n_n_next;
      ext_n_reg <= ext_n_next;
      lock_n_reg <= lock_n_next;
      ctrl_oe_reg <= ctrl_oe_next;
      data_oe_reg <= data_oe_next;
      wr_reg <= wr_next;
      ext_ok_reg <= ext_ok_next;
      rd_valid_reg <= rd_valid_next;
      done_reg <= done_next;
      addr_reg <= addr_next;
      be_reg <= be_next;
      len_reg <= len_next;
      cnt_reg <= cnt_next;
      wdata_reg <= wdata_next;
      rd_reg <= rd_next;
      wbuf_reg <= wbuf_next;
    end
  end
endmodule
`default_nettype wire

/* common/mdbp_pkg.sv */
// constants and types shared by both ends of the module bus port
// Functional notes
// - master requests, drives only after grant
// - all signals clocked on module clock rise
// - drive strobes high one clock before release
// - strobe starts cycle, ready ends each transfer
// - extend only on single reads, optional
// - extended read holds data and ready
// - last-transfer held whole extended read
// - never extend a burst
// - never extend a write
// - strobe only once write data valid
// - refresh adds up to ten ready waits
// - master waits only on ready
// - extended read ends: last, ready, no extend
// - extend only after the strobe
// - arbiter grants once other masters release
// - lock held across atomic read-modify-write
package mdbp_pkg;
  localparam int MDBP_ADDR_W = 30;
  localparam int MDBP_DATA_W = 32;
  localparam int MDBP_BE_W = 4;
  localparam int MDBP_LEN_W = 3;
  localparam int MDBP_BURST_MAX = 4;
  localparam int MDBP_WAIT_W = 4;
  localparam int MDBP_WAIT_STATES = 1;
  localparam int MDBP_REFRESH_EXTRA = 10;
  localparam int MDBP_MEM_AW = 4;

  typedef logic [MDBP_ADDR_W-1:0] mdbp_addr_t;
  typedef logic [MDBP_DATA_W-1:0] mdbp_data_t;
  typedef logic [MDBP_BE_W-1:0] mdbp_be_t;
  typedef logic [MDBP_LEN_W-1:0] mdbp_len_t;

  typedef enum logic [5:0] {
    MDBP_M_IDLE = 6'b000001,
    MDBP_M_REQ = 6'b000010,
    MDBP_M_OWN = 6'b000100,
    MDBP_M_ADDR = 6'b001000,
    MDBP_M_DATA = 6'b010000,
    MDBP_M_PARK = 6'b100000
  } mdbp_mstate_t;

  typedef enum logic [2:0] {
    MDBP_D_IDLE = 3'b001,
    MDBP_D_WAIT = 3'b010,
    MDBP_D_READY = 3'b100
  } mdbp_dstate_t;
endpackage

/* common/mdbp_if.sv */
// shared bus between module master and board arbiter and memory controller
`timescale 1ns/1ns
`default_nettype none
interface mdbp_if;
  import mdbp_pkg::*;
  logic m_req_n;
  logic m_ads_n;
  logic m_last_transfer_n_n;
  logic m_extend_n;
  logic m_lock_n;
  logic m_ctrl_oe;
  logic m_wr;
  mdbp_addr_t m_addr;
  mdbp_be_t m_be;
  mdbp_data_t m_data;
  logic m_data_oe;
  logic d_grant_n;
  logic d_ready_n;
  mdbp_data_t d_data;
  logic d_data_oe;
  logic ads_n;
  logic last_transfer_n_n;
  logic extend_n;
  logic lock_n;
  logic wr;
  mdbp_addr_t addr;
  mdbp_be_t be;
  mdbp_data_t data;

  // released strobes float high through board pull-ups
  assign ads_n = m_ctrl_oe ? m_ads_n : 1'b1;
  assign last_transfer_n_n = m_ctrl_oe ? m_last_transfer_n_n : 1'b1;
  assign extend_n = m_ctrl_oe ? m_extend_n : 1'b1;
  assign lock_n = m_ctrl_oe ? m_lock_n : 1'b1;
  assign wr = m_ctrl_oe ? m_wr : 1'b0;
  assign addr = m_ctrl_oe ? m_addr : '0;
  assign be = m_ctrl_oe ? m_be : '1;
  assign data = d_data_oe ? d_data : (m_data_oe ? m_data : '0);

  modport master (
    output m_req_n, m_ads_n, m_last_transfer_n_n, m_extend_n, m_lock_n, m_ctrl_oe,
    output m_wr, m_addr, m_be, m_data, m_data_oe,
    input d_grant_n, d_ready_n, data
  );
  modport device (
    input m_req_n, ads_n, last_transfer_n_n, extend_n, lock_n, wr, addr, be, data,
    output d_grant_n, d_ready_n, d_data, d_data_oe
  );
endinterface
`default_nettype wire

/* logic/mdbp_board.sv */
// board end: bus arbiter and shared memory controller
`timescale 1ns/1ns
`default_nettype none
module mdbp_board #(
  parameter int WAIT_STATES = mdbp_pkg::MDBP_WAIT_STATES,
  parameter int REFRESH_EXTRA = mdbp_pkg::MDBP_REFRESH_EXTRA
) (
  input wire logic mclk,
  input wire logic resetn,
  mdbp_if.device bus,
  input wire logic refresh_req,
  input wire logic other_busy,
  input wire logic release_req,
  output logic granted,
  output logic refresh_hit
);
  import mdbp_pkg::*;
  localparam logic [MDBP_WAIT_W-1:0] WS = MDBP_WAIT_W'(WAIT_STATES);
  localparam logic [MDBP_WAIT_W-1:0] RX = MDBP_WAIT_W'(REFRESH_EXTRA);

  mdbp_dstate_t state_reg, state_next;
  logic grant_n_reg, grant_n_next;
  logic gprev_n_reg, gprev_n_next;
  logic ready_n_reg, ready_n_next;
  logic oe_reg, oe_next;
  logic hit_reg, hit_next;
  logic wr_reg, wr_next;
  logic [MDBP_WAIT_W-1:0] cnt_reg, cnt_next;
  logic [MDBP_MEM_AW-1:0] idx_reg, idx_next;
  mdbp_be_t be_reg, be_next;
  mdbp_data_t rd_reg, rd_next;
  mdbp_data_t mem [0:(1<<MDBP_MEM_AW)-1];
  logic mem_we;
  mdbp_data_t mem_wd;

  assign bus.d_grant_n = grant_n_reg;
  assign bus.d_ready_n = ready_n_reg;
  assign bus.d_data = rd_reg;
  assign bus.d_data_oe = oe_reg;
  assign granted = ~grant_n_reg;
  assign refresh_hit = hit_reg;

  // arbitration and memory cycle sequencing
  always_comb begin
    state_next = state_reg;
    grant_n_next = grant_n_reg;
    gprev_n_next = grant_n_reg;
    ready_n_next = ready_n_reg;
    oe_next = oe_reg;
    hit_next = 1'b0;
    wr_next = wr_reg;
    cnt_next = cnt_reg;
    idx_next = idx_reg;
    be_next = be_reg;
    rd_next = rd_reg;
    mem_we = 1'b0;
    mem_wd = bus.data;
    for (int i = 0; i < MDBP_BE_W; i++) begin
      if (!be_reg[i]) begin
        mem_wd[i*8 +: 8] = bus.data[i*8 +: 8];
      end else begin
        mem_wd[i*8 +: 8] = mem[idx_reg][i*8 +: 8];
      end
    end
    // grant once other masters leave, drop on release between cycles
    if (grant_n_reg) begin
      if (!bus.m_req_n && !other_busy && state_reg == MDBP_D_IDLE) begin
        grant_n_next = 1'b0;
      end
    end else if (bus.m_req_n || (release_req && state_reg == MDBP_D_IDLE && bus.ads_n)) begin
      grant_n_next = 1'b1;
    end
    case (state_reg)
      MDBP_D_IDLE: begin
        // a strobe launched on the last granted edge is still honoured
        if (!bus.ads_n && !(grant_n_reg && gprev_n_reg)) begin
          wr_next = bus.wr;
          idx_next = bus.addr[MDBP_MEM_AW-1:0];
          be_next = bus.be;
          cnt_next = refresh_req ? WS + RX : WS;
          hit_next = refresh_req;
          state_next = MDBP_D_WAIT;
        end
      end
      MDBP_D_WAIT: begin
        if (cnt_reg == '0) begin
          ready_n_next = 1'b0;
          oe_next = ~wr_reg;
          rd_next = mem[idx_reg];
          state_next = MDBP_D_READY;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      MDBP_D_READY: begin
        if (bus.extend_n || wr_reg) begin
          mem_we = wr_reg;
          ready_n_next = 1'b1;
          oe_next = 1'b0;
          if (!bus.last_transfer_n_n) begin
            state_next = MDBP_D_IDLE;
          end else begin
            idx_next = idx_reg + 1'b1;
            cnt_next = WS;
            state_next = MDBP_D_WAIT;
          end
        end
        // extend seen low: ready and data stay put
      end
      default: begin
        state_next = MDBP_D_IDLE;
        ready_n_next = 1'b1;
        oe_next = 1'b0;
      end
    endcase
  end

  // state registers, synchronous reset
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_reg <= MDBP_D_IDLE;
      grant_n_reg <= 1'b1;
      gprev_n_reg <= 1'b1;
      ready_n_reg <= 1'b1;
      oe_reg <= 1'b0;
      hit_reg <= 1'b0;
      wr_reg <= 1'b0;
      cnt_reg <= '0;
      idx_reg <= '0;
      be_reg <= '1;
      rd_reg <= '0;
    end else begin
      state_reg <= state_next;
      grant_n_reg <= grant_n_next;
      gprev_n_reg <= gprev_n_next;
      ready_n_reg <= ready_n_next;
      oe_reg <= oe_next;
      hit_reg <= hit_next;
      wr_reg <= wr_next;
      cnt_reg <= cnt_next;
      idx_reg <= idx_next;
      be_reg <= be_next;
      rd_reg <= rd_next;
    end
  end

  // shared memory storage
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[idx_reg] <= mem_wd;
    end
  end
endmodule
`default_nettype wire

/* bench/mdbp_props.sv */
// concurrent checks on the shared bus between master and board ends
`timescale 1ns/1ns
`default_nettype none
module mdbp_props (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic m_req_n,
  input wire logic m_ads_n,
  input wire logic m_last_transfer_n_n,
  input wire logic m_extend_n,
  input wire logic m_lock_n,
  input wire logic m_ctrl_oe,
  input wire logic m_data_oe,
  input wire logic d_grant_n,
  input wire logic d_ready_n,
  input wire mdbp_pkg::mdbp_data_t d_data,
  input wire logic ads_n,
  input wire logic last_transfer_n_n,
  input wire logic extend_n,
  input wire logic wr
);
  import mdbp_pkg::*;
  // ready window after the strobe: normal waits, plus refresh extra
  localparam int READY_MIN = MDBP_WAIT_STATES + 1;
  localparam int READY_MAX = READY_MIN + MDBP_REFRESH_EXTRA;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  // master side: ownership, parking and strobe shape
  a_park_high: assert property (
    $fell(m_ctrl_oe) |-> $past(m_ads_n & m_last_transfer_n_n & m_extend_n & m_lock_n))
    else $error("strobes not parked high before release");
  a_drive_grant: assert property (
    $rose(m_ctrl_oe) |-> $past(!d_grant_n))
    else $error("bus driven without grant");
  a_ads_owned: assert property (
    !m_ads_n |-> m_ctrl_oe && !m_req_n)
    else $error("strobe without ownership or request");
  a_ads_pulse: assert property (
    !m_ads_n |=> m_ads_n)
    else $error("strobe longer than one cycle");
  a_wdata_first: assert property (
    !ads_n && wr |-> m_data_oe)
    else $error("write strobe before data driven");
  // extend only on single reads, after the strobe
  a_ext_single: assert property (
    !extend_n |-> !last_transfer_n_n && !wr)
    else $error("extend outside single read");
  a_ext_after_ads: assert property (
    $fell(extend_n) |-> $past(!ads_n))
    else $error("extend not right after strobe");
  // board side: ready timing and held read data, then both ends idle after reset
  a_ext_hold: assert property (
    !extend_n && !d_ready_n |=> !d_ready_n && $stable(d_data))
    else $error("ready or data dropped while extended");
  a_ready_end: assert property (
    !d_ready_n && extend_n && !last_transfer_n_n |=> d_ready_n)
    else $error("cycle not ended on last ready");
  a_ready_wait: assert property (
    !ads_n |=> d_ready_n ##[READY_MIN:READY_MAX] !d_ready_n)
    else $error("ready outside wait window");
  a_reset_idle: assert property (
    $rose(resetn) |-> m_req_n && !m_ctrl_oe && d_grant_n)
    else $error("not idle after reset");
endmodule
`default_nettype wire

/* bench/mdbp_tb.sv */
// testbench joining master and board ends through the shared bus
`timescale 1ns/1ns
`default_nettype none
module mdbp_tb;
  import mdbp_pkg::*;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic cmd_write = 1'b0;
  mdbp_addr_t cmd_addr = '0;
  mdbp_be_t cmd_be = '0;
  mdbp_len_t cmd_len = '0;
  logic cmd_extend = 1'b0;
  logic cmd_lock = 1'b0;
  logic [4*MDBP_DATA_W-1:0] cmd_wdata = '0;
  logic hold_read = 1'b0;
  logic rd_valid;
  mdbp_data_t rd_data;
  logic xfer_done;
  logic bus_owned;
  logic refresh_req = 1'b0;
  logic other_busy = 1'b0;
  logic release_req = 1'b0;
  logic granted;
  logic refresh_hit;
  logic rnd = 1'b0;
  logic hit_pend = 1'b0;
  int seed = 50;
  int n_fail = 0;
  int samples_checked = 0;
  mdbp_data_t exp_q[$];
  mdbp_data_t mem[16];

  mdbp_if mdbp_if_i ();
  mdbp_master mdbp_master_i (.mclk(mclk), .resetn(resetn), .bus(mdbp_if_i.master),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_be(cmd_be), .cmd_len(cmd_len), .cmd_extend(cmd_extend), .cmd_lock(cmd_lock),
    .cmd_wdata(cmd_wdata), .hold_read(hold_read), .rd_valid(rd_valid), .rd_data(rd_data),
    .xfer_done(xfer_done), .bus_owned(bus_owned));
  mdbp_board mdbp_board_i (.mclk(mclk), .resetn(resetn), .bus(mdbp_if_i.device),
    .refresh_req(refresh_req), .other_busy(other_busy), .release_req(release_req),
    .granted(granted), .refresh_hit(refresh_hit));
  mdbp_props mdbp_props_i (.mclk(mclk), .resetn(resetn), .m_req_n(mdbp_if_i.m_req_n),
    .m_ads_n(mdbp_if_i.m_ads_n), .m_last_transfer_n_n(mdbp_if_i.m_last_transfer_n_n),
    .m_extend_n(mdbp_if_i.m_extend_n), .m_lock_n(mdbp_if_i.m_lock_n),
    .m_ctrl_oe(mdbp_if_i.m_ctrl_oe), .m_data_oe(mdbp_if_i.m_data_oe),
    .d_grant_n(mdbp_if_i.d_grant_n), .d_ready_n(mdbp_if_i.d_ready_n),
    .d_data(mdbp_if_i.d_data), .ads_n(mdbp_if_i.ads_n), .last_transfer_n_n(mdbp_if_i.last_transfer_n_n),
    .extend_n(mdbp_if_i.extend_n), .wr(mdbp_if_i.wr));

  // 100 MHz clock
  always #5 mclk = ~mclk;

  task automatic check(input mdbp_data_t seen, input mdbp_data_t want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic end_sim();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // notes expected words, issues one command and waits for its completion
  task automatic send(input logic w, input mdbp_addr_t a, input mdbp_be_t b,
                      input mdbp_len_t l, input logic x, input logic k);
    int n;
    int t;
    logic [3:0] idx;
    logic [4*MDBP_DATA_W-1:0] wd;
    n = (l == 0) ? 1 : ((l > 4) ? 4 : int'(l));
    wd = {$random(seed), $random(seed), $random(seed), $random(seed)};
    for (int i = 0; i < n; i++) begin
      idx = a[3:0] + 4'(i);
      for (int j = 0; j < 4; j++) begin
        if (w && !b[j]) mem[idx][8*j +: 8] = wd[32*i+8*j +: 8];
      end
      if (!w) exp_q.push_back(mem[idx]);
    end
    cmd_write <= w;
    cmd_addr <= a;
    cmd_be <= b;
    cmd_len <= l;
    cmd_extend <= x;
    cmd_lock <= k;
    cmd_wdata <= wd;
    hold_read <= x;
    cmd_valid <= 1'b1;
    t = 0;
    do begin
      @(posedge mclk);
      t++;
    end while (cmd_ready !== 1'b1 && t < 300);
    cmd_valid <= 1'b0;
    t = 0;
    while (xfer_done !== 1'b1 && t < 300) begin
      @(posedge mclk);
      t++;
      if (t == 5 && xfer_done !== 1'b1) hold_read <= 1'b0; // end the extension
    end
    check(32'(xfer_done), 32'h1);
    if (k) check(32'(mdbp_if_i.lock_n), 32'h0);
  endtask

  // each returned read word is compared with the oldest note
  always @(posedge mclk) begin
    if (rd_valid === 1'b1) check(rd_data, (exp_q.size() > 0) ? exp_q.pop_front() : 'x);
  end

  // a refresh met by an accepted strobe is flagged one cycle later
  always @(posedge mclk) begin
    if (resetn === 1'b1) check(32'(refresh_hit), 32'(hit_pend));
    hit_pend = (mdbp_if_i.ads_n === 1'b0) && (refresh_req === 1'b1);
  end

  // random refresh collisions and grant removals during the mixed phase
  always @(posedge mclk) begin
    if (rnd) begin
      refresh_req <= ($random(seed) % 3) == 0;
      release_req <= ($random(seed) % 16) == 0;
    end else begin
      refresh_req <= 1'b0;
      release_req <= 1'b0;
    end
  end

  // main sequence
  initial begin
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    for (int i = 0; i < 4; i++) send(1'b1, 30'(4*i), '0, (i == 1) ? 3'h7 : 3'h4, 1'b1, 1'b0);
    send(1'b0, 30'h0, '0, 3'h4, 1'b1, 1'b0);
    send(1'b0, 30'h5, '0, 3'h2, 1'b0, 1'b0);
    send(1'b0, 30'h9, '0, 3'h0, 1'b1, 1'b1);
    send(1'b0, 30'ha, '0, 3'h1, 1'b0, 1'b0);
    repeat (8) @(posedge mclk);
    other_busy <= 1'b1;
    fork
      begin
        repeat (6) @(posedge mclk);
        check(32'(granted), 32'h0);
        other_busy <= 1'b0;
      end
    join_none
    send(1'b1, 30'h3, 4'h5, 3'h1, 1'b0, 1'b0);
    send(1'b0, 30'h3, '0, 3'h1, 1'b1, 1'b0);
    rnd <= 1'b1;
    repeat (40) send(1'($random(seed)), 30'($random(seed)), 4'($random(seed)),
                     3'($random(seed)), 1'($random(seed)), 1'b0);
    rnd <= 1'b0;
    resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    check(32'(bus_owned), 32'h0);
    check(32'(granted), 32'h0);
    check(32'(exp_q.size()), 32'h0);
    end_sim();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
endmodule
`default_nettype wire
